// ==== core/tmz_timer.sv ====
`timescale 1ns/1ps

module tmz_timer
    import tmz_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tmz_pkg::tmz_avs_req_s avs_req,
    output tmz_pkg::tmz_avs_rsp_s avs_rsp,
    input wire logic timer_clk_pin,
    input wire logic hf_osc,
    input wire logic lf_osc,
    input wire logic mf_osc,
    input wire logic sec_osc,
    input wire logic logic_cell_in,
    input wire logic sleep_mode,
    output logic timer_output_signal,
    output logic timer_irq,
    output logic wake_req
);

    // ==========================================================
    // State
    tmz_state_s st;
    tmz_state_s next_st;

    logic [TMZ_NUM_SRC-1:0] src_raw;
    logic [TMZ_NUM_SRC-1:0] src_rise;
    logic [TMZ_NUM_SRC-1:0] src_fall;
    logic src_edge;
    logic run;
    logic [14:0] pre_mask;
    logic pre_tick;
    logic evt;
    logic flag_set;
    logic flag_clr;
    logic acc;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic [7:0] wbyte;
    logic scaler_clr;

    assign src_raw = {logic_cell_in, sec_osc, mf_osc, lf_osc, hf_osc, timer_clk_pin};

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;

        // Three-stage sampling; edges judged on the two later stages only
        next_st.s1 = src_raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        src_rise = st.s2 & ~st.s3;
        src_fall = ~st.s2 & st.s3;

        // Source select
        case (st.cs)
            TMZ_CS_PIN: begin
                src_edge = src_rise[0];
            end
            TMZ_CS_PIN_INV: begin
                src_edge = src_fall[0];
            end
            TMZ_CS_INSTR: begin
                src_edge = ~sleep_mode;
            end
            default: begin
                src_edge = src_rise[3'(st.cs - TMZ_CS_SRC_BASE)];
            end
        endcase

        // Synchronous mode halts in sleep; asynchronous mode keeps counting on every source except the instruction clock
        run = st.en & src_edge & (st.unsynchronized_input_in | ~sleep_mode);

        // Prescaler: ratio 2^pre_sel
        pre_mask = 15'((16'h0001 << st.pre_sel) - 16'h0001);
        pre_tick = run & (st.pre_cnt == pre_mask);
        if (run) begin
            next_st.pre_cnt = pre_tick ? 15'h0000 : 15'(st.pre_cnt + 15'h0001);
        end

        // Counter
        evt = 1'b0;
        if (pre_tick) begin
            if (st.wide_mode_select) begin
                {next_st.cnt_hi, next_st.cnt_lo} = 16'({st.cnt_hi, st.cnt_lo} + 16'h0001);
                evt = &{st.cnt_hi, st.cnt_lo};
            end else if (st.cnt_lo == st.period_buf) begin
                next_st.cnt_lo = TMZ_BYTE_RST;
                next_st.period_buf = st.hi_reg;
                evt = 1'b1;
            end else begin
                next_st.cnt_lo = 8'(st.cnt_lo + 8'h01);
            end
        end

        // Postscaler and output toggle
        flag_set = 1'b0;
        if (evt) begin
            if (st.post_cnt == st.post_sel) begin
                next_st.post_cnt = 4'h0;
                next_st.out = ~st.out;
                flag_set = 1'b1;
            end else begin
                next_st.post_cnt = 4'(st.post_cnt + 4'h1);
            end
        end

        // Bus slave: one wait cycle, then answer for one cycle
        acc = (avs_req.read | avs_req.write) & st.rsp.waitrequest;
        // A write lands at the edge where the master sees waitrequest low, never earlier
        wr = avs_req.write & ~st.rsp.waitrequest & avs_req.byteenable[0];
        rd = acc & avs_req.read;
        idx = avs_req.address[11:2];
        wbyte = avs_req.writedata[7:0];
        next_st.rsp.waitrequest = ~acc;
        scaler_clr = 1'b0;
        flag_clr = 1'b0;

        if (wr) begin
            case (idx)
                TMZ_IDX_COUNT_LOW: begin
                    scaler_clr = 1'b1;
                    if (!(st.wide_mode_select && st.en)) begin
                        next_st.cnt_lo = wbyte;
                        if (st.wide_mode_select) begin
                            next_st.cnt_hi = st.hi_reg;
                        end
                    end
                end
                TMZ_IDX_COUNT_HIGH: begin
                    next_st.hi_reg = wbyte;
                end
                TMZ_IDX_CTRL_A: begin
                    scaler_clr = 1'b1;
                    next_st.en = wbyte[TMZ_CTLA_EN_BIT];
                    next_st.wide_mode_select = wbyte[TMZ_CTLA_WIDE_BIT];
                    next_st.post_sel = wbyte[TMZ_CTLA_POST_LSB +: 4];
                end
                TMZ_IDX_CTRL_B: begin
                    scaler_clr = 1'b1;
                    next_st.cs = wbyte[TMZ_CTLB_CS_LSB +: 3];
                    next_st.unsynchronized_input_in = wbyte[TMZ_CTLB_UNSYNCHRONIZED_INPUT_BIT];
                    next_st.pre_sel = wbyte[TMZ_CTLB_PRE_LSB +: 4];
                end
                TMZ_IDX_IRQ_CTRL: begin
                    next_st.irq_en = wbyte[TMZ_IRQ_ENABLE_BIT];
                    flag_clr = wbyte[TMZ_IRQ_FLAG_BIT];
                end
                default: begin
                end
            endcase
        end

        if (scaler_clr) begin
            next_st.pre_cnt = 15'h0000;
            next_st.post_cnt = 4'h0;
        end

        if (rd) begin
            case (idx)
                TMZ_IDX_COUNT_LOW: begin
                    next_st.rsp.readdata = {24'h000000, st.cnt_lo};
                    if (st.wide_mode_select) begin
                        next_st.hi_reg = st.cnt_hi;
                    end
                end
                TMZ_IDX_COUNT_HIGH: begin
                    next_st.rsp.readdata = {24'h000000, st.hi_reg};
                end
                TMZ_IDX_CTRL_A: begin
                    next_st.rsp.readdata = 32'h00000000;
                    next_st.rsp.readdata[TMZ_CTLA_EN_BIT] = st.en;
                    next_st.rsp.readdata[TMZ_CTLA_OUT_BIT] = st.out;
                    next_st.rsp.readdata[TMZ_CTLA_WIDE_BIT] = st.wide_mode_select;
                    next_st.rsp.readdata[TMZ_CTLA_POST_LSB +: 4] = st.post_sel;
                end
                TMZ_IDX_CTRL_B: begin
                    next_st.rsp.readdata = 32'h00000000;
                    next_st.rsp.readdata[TMZ_CTLB_CS_LSB +: 3] = st.cs;
                    next_st.rsp.readdata[TMZ_CTLB_UNSYNCHRONIZED_INPUT_BIT] = st.unsynchronized_input_in;
                    next_st.rsp.readdata[TMZ_CTLB_PRE_LSB +: 4] = st.pre_sel;
                end
                TMZ_IDX_IRQ_CTRL: begin
                    next_st.rsp.readdata = 32'h00000000;
                    next_st.rsp.readdata[TMZ_IRQ_FLAG_BIT] = st.flag;
                    next_st.rsp.readdata[TMZ_IRQ_ENABLE_BIT] = st.irq_en;
                end
                default: begin
                    next_st.rsp.readdata = 32'h00000000;
                end
            endcase
        end

        // Sticky flag; a new toggle wins over a clear in the same cycle
        next_st.flag = (st.flag & ~flag_clr) | flag_set;
        next_st.irq = next_st.flag & next_st.irq_en;
        next_st.wake = next_st.irq & sleep_mode & st.unsynchronized_input_in;
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.rsp.waitrequest <= 1'b1;
            st.hi_reg <= TMZ_COUNT_HIGH_RST;
            st.period_buf <= TMZ_COUNT_HIGH_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_rsp = st.rsp;
    assign timer_output_signal = st.out;
    assign timer_irq = st.irq;
    assign wake_req = st.wake;

endmodule // tmz_timer

// ==== shared/tmz_pkg.sv ====
package tmz_pkg;

    // ==========================================================
    // Register map: printed offsets are register indices, byte address = 4 * index
    localparam logic [9:0] TMZ_IDX_COUNT_LOW = 10'h318;
    localparam logic [9:0] TMZ_IDX_COUNT_HIGH = 10'h319;
    localparam logic [9:0] TMZ_IDX_CTRL_A = 10'h31A;
    localparam logic [9:0] TMZ_IDX_CTRL_B = 10'h31B;
    localparam logic [9:0] TMZ_IDX_IRQ_CTRL = 10'h31C;

    // ==========================================================
    // Field positions
    localparam int unsigned TMZ_CTLA_EN_BIT = 7;
    localparam int unsigned TMZ_CTLA_OUT_BIT = 5;
    localparam int unsigned TMZ_CTLA_WIDE_BIT = 4;
    localparam int unsigned TMZ_CTLA_POST_LSB = 0;
    localparam int unsigned TMZ_CTLB_CS_LSB = 5;
    localparam int unsigned TMZ_CTLB_UNSYNCHRONIZED_INPUT_BIT = 4;
    localparam int unsigned TMZ_CTLB_PRE_LSB = 0;
    localparam int unsigned TMZ_IRQ_FLAG_BIT = 0;
    localparam int unsigned TMZ_IRQ_ENABLE_BIT = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] TMZ_COUNT_HIGH_RST = 8'hFF;
    localparam logic [7:0] TMZ_BYTE_RST = 8'h00;

    // ==========================================================
    // Clock source select codes
    localparam logic [2:0] TMZ_CS_PIN = 3'h0;
    localparam logic [2:0] TMZ_CS_PIN_INV = 3'h1;
    localparam logic [2:0] TMZ_CS_INSTR = 3'h2;
    localparam logic [2:0] TMZ_CS_SRC_BASE = 3'h2;
    localparam int unsigned TMZ_NUM_SRC = 6;

    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } tmz_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } tmz_avs_rsp_s;

    typedef struct packed {
        tmz_avs_rsp_s rsp;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] hi_reg;
        logic [7:0] period_buf;
        logic en;
        logic out;
        logic wide_mode_select;
        logic [3:0] post_sel;
        logic [2:0] cs;
        logic unsynchronized_input_in;
        logic [3:0] pre_sel;
        logic [14:0] pre_cnt;
        logic [3:0] post_cnt;
        logic flag;
        logic irq_en;
        logic irq;
        logic wake;
        logic [TMZ_NUM_SRC-1:0] s1;
        logic [TMZ_NUM_SRC-1:0] s2;
        logic [TMZ_NUM_SRC-1:0] s3;
    } tmz_state_s;

endpackage

// ==== verification/tmz_timer_sva.sv ====
`timescale 1ns/1ps
// ==========
// Bus and output checks
module tmz_timer_sva
    import tmz_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tmz_pkg::tmz_avs_req_s avs_req,
    input wire tmz_pkg::tmz_avs_rsp_s avs_rsp,
    input wire logic sleep_mode,
    input wire logic timer_output_signal,
    input wire logic timer_irq,
    input wire logic wake_req
);
    logic rd_go;
    logic wr_go;
    assign rd_go = avs_req.read & avs_rsp.waitrequest;
    assign wr_go = avs_req.write & avs_rsp.waitrequest;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_answer_next: assert property ((rd_go | wr_go) |=> !avs_rsp.waitrequest) else $error("no answer");
    a_wait_single: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest) else $error("long answer");
    a_answer_caused: assert property ($fell(avs_rsp.waitrequest) |-> $past(rd_go | wr_go)) else $error("stray answer");
    a_data_byte: assert property (!avs_rsp.waitrequest |-> avs_rsp.readdata[31:8] == 24'h0) else $error("high bits");
    a_data_hold: assert property (!rd_go |=> $stable(avs_rsp.readdata)) else $error("read data moved");
    a_out_status: assert property (rd_go && avs_req.address[11:2] == TMZ_IDX_CTRL_A
        |=> avs_rsp.readdata[TMZ_CTLA_OUT_BIT] == $past(timer_output_signal)) else $error("out bit wrong");
    a_flag_sticky: assert property (timer_irq && !(avs_req.write && !avs_rsp.waitrequest
        && avs_req.address[11:2] == TMZ_IDX_IRQ_CTRL)
        |=> timer_irq) else $error("irq dropped");
    a_wake_sleep: assert property (wake_req |-> $past(sleep_mode)) else $error("wake while awake");
endmodule // tmz_timer_sva
bind tmz_timer tmz_timer_sva u_sva (.ref_clk(ref_clk), .nrst(nrst), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .sleep_mode(sleep_mode), .timer_output_signal(timer_output_signal), .timer_irq(timer_irq), .wake_req(wake_req));

// ==== verification/timer_eight_sixteen_bit_test.sv ====
`timescale 1ns/1ps
module timer_eight_sixteen_bit_test;
    import tmz_pkg::*;
    logic ref_clk, nrst, sleep_mode, tout, tirq, wake;
    logic [5:0] src;
    logic [15:0] rd;
    tmz_avs_req_s req;
    tmz_avs_rsp_s rsp;
    int fails, num_checks, cyc, p, n, k, t0, t1, asy;

    tmz_timer uut (.ref_clk(ref_clk), .nrst(nrst), .avs_req(req), .avs_rsp(rsp), .timer_clk_pin(src[0]),
        .hf_osc(src[1]), .lf_osc(src[2]), .mf_osc(src[3]), .sec_osc(src[4]), .logic_cell_in(src[5]),
        .sleep_mode(sleep_mode), .timer_output_signal(tout), .timer_irq(tirq), .wake_req(wake));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ==========
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        req.read <= !wr;
        req.write <= wr;
        req.address <= {idx, 2'b00};
        req.writedata <= {24'h0, d};
        do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata[15:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wait_tog(input int lim);
        logic o;
        o = tout;
        for (int i = 0; i < lim && tout === o; i++) @(posedge ref_clk);
        check(16'(tout !== o), 16'h1);
        t1 = cyc;
    endtask

    task automatic wrap_up();
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc > 95000) begin
            fails++;
            wrap_up();
        end
    end

    // ==========
    // Scenarios
    initial begin
        void'($urandom(10784));
        nrst = 1'b0; sleep_mode = 1'b0; src = '0; req = '0; req.byteenable = 4'hF;
        fails = 0; num_checks = 0; cyc = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus(0, TMZ_IDX_COUNT_HIGH, 8'h0); check(rd, 16'hFF);
        bus(0, TMZ_IDX_CTRL_A, 8'h0); check(rd, 16'h00);
        bus(0, TMZ_IDX_CTRL_B, 8'h0); check(rd, 16'h00);
        bus(0, 10'h000, 8'h0); check(rd, 16'h00);
        // Every source code except the instruction clock (code 2) counts k pulses of its own input
        for (int cs = 0; cs < 8; cs++) begin
            if (cs == 2) continue;
            k = 1 + $urandom % 5;
            asy = $urandom % 2;
            bus(1, TMZ_IDX_CTRL_A, 8'h10); bus(1, TMZ_IDX_COUNT_HIGH, 8'h0); bus(1, TMZ_IDX_COUNT_LOW, 8'h0);
            bus(1, TMZ_IDX_CTRL_B, {3'(cs), 1'(asy), 4'h0});
            sleep_mode <= 1'(asy);
            bus(1, TMZ_IDX_CTRL_A, 8'h90);
            repeat (k) begin
                src[cs < 2 ? 0 : cs - 2] <= 1'b1;
                repeat (6) @(posedge ref_clk);
                src[cs < 2 ? 0 : cs - 2] <= 1'b0;
                repeat (6) @(posedge ref_clk);
            end
            sleep_mode <= 1'b0;
            bus(0, TMZ_IDX_COUNT_LOW, 8'h0); check(rd, 16'(k));
        end
        // Synchronous count halts in sleep
        bus(1, TMZ_IDX_CTRL_A, 8'h10); bus(1, TMZ_IDX_CTRL_B, 8'h40);
        sleep_mode <= 1'b1;
        bus(1, TMZ_IDX_CTRL_A, 8'h90); bus(0, TMZ_IDX_COUNT_LOW, 8'h0);
        p = rd;
        repeat (20) @(posedge ref_clk);
        bus(0, TMZ_IDX_COUNT_LOW, 8'h0); check(rd, 16'(p));
        sleep_mode <= 1'b0;
        // Wide mode buffered access, write refused while running, wrap
        bus(1, TMZ_IDX_CTRL_A, 8'h10); bus(1, TMZ_IDX_COUNT_HIGH, 8'h12); bus(1, TMZ_IDX_COUNT_LOW, 8'h34);
        bus(0, TMZ_IDX_COUNT_LOW, 8'h0); check(rd, 16'h34);
        bus(0, TMZ_IDX_COUNT_HIGH, 8'h0); check(rd, 16'h12);
        bus(1, TMZ_IDX_COUNT_HIGH, 8'hFF); bus(1, TMZ_IDX_COUNT_LOW, 8'hE0);
        bus(1, TMZ_IDX_CTRL_A, 8'h90); bus(1, TMZ_IDX_COUNT_LOW, 8'h00);
        wait_tog(60);
        bus(0, TMZ_IDX_COUNT_LOW, 8'h0); bus(0, TMZ_IDX_COUNT_HIGH, 8'h0); check(rd, 16'h00);
        bus(0, TMZ_IDX_IRQ_CTRL, 8'h0); check(rd, 16'h01);
        bus(1, TMZ_IDX_IRQ_CTRL, 8'h01); bus(0, TMZ_IDX_IRQ_CTRL, 8'h0); check(rd, 16'h00);
        // Narrow mode period, prescale and postscale timing
        for (int i = 0; i < 13; i++) begin
            p = (i < 4) ? $urandom % 20 : 0;
            n = (i == 0) ? 15 : (i < 4) ? $urandom % 16 : 0;
            bus(1, TMZ_IDX_CTRL_A, 8'h00); bus(1, TMZ_IDX_COUNT_HIGH, 8'(p)); bus(1, TMZ_IDX_COUNT_LOW, 8'h0);
            bus(1, TMZ_IDX_CTRL_B, {4'h4, 4'(i)}); bus(1, TMZ_IDX_IRQ_CTRL, 8'h03);
            bus(1, TMZ_IDX_CTRL_A, {4'h8, 4'(n)});
            wait_tog(20000);
            wait_tog(20000);
            t0 = t1;
            wait_tog(20000);
            check(16'(t1 - t0), 16'((p + 1) * (n + 1) * (1 << i)));
            bus(0, TMZ_IDX_IRQ_CTRL, 8'h0); check(rd, 16'h03);
            check(16'(tirq), 16'h1);
            bus(1, TMZ_IDX_CTRL_B, {4'h5, 4'(i)});
            sleep_mode <= 1'b1;
            repeat (3) @(posedge ref_clk);
            check(16'(wake), 16'h1);
            sleep_mode <= 1'b0;
        end
        wrap_up();
    end
endmodule // timer_eight_sixteen_bit_test
